// [src/fpu_exc_pkg.sv]
// constants and types for the divide-by-zero, overflow, underflow unit
// Overview of operation
// - raise divide-by-zero when a finite non-zero operand is divided by 0
// - divide-by-zero flag is status bit 2, its mask control bit 2
// - only divides, log2-multiply and exponent-extract report divide-by-zero
// - masked divide-by-zero: set flag, write substitute, no handler
// - unmasked divide-by-zero: set flag, request handler, keep stack and sources
// - masked divide by zero returns infinity signed by xor of operand signs
// - masked log2-multiply returns infinity opposite to the non-zero operand sign
// - masked extract: second entry minus infinity, top signed zero
// - raise overflow when rounded result exceeds destination's largest finite value
// - overflow on register results and float stores; integer stores signal invalid
// - overflow flag is status bit 3, its mask control bit 3
// - masked overflow writes a substitute chosen by the rounding mode
// - unmasked overflow to memory: set flag, request handler, clear C1, write nothing
// - unmasked overflow to register: subtract 24576 from exponent, store, trap
// - rebiased register result sets C1 when rounded up, clears it otherwise
// - scale still overflowing after rebias stores signed infinity
// - detect underflow when rounded result is below smallest normal value
// - integer and packed stores never report underflow
// - underflow flag is status bit 4, its mask control bit 4
// - unmasked underflow to memory: set flag, request handler, write nothing
// - unmasked underflow to register: add 24576 to exponent, store, trap
// - scale still underflowing after rebias stores signed zero
// - round-up condition bit sits at status bit 9
// - pending unmasked fault held in error summary, trapped at next check
package fpu_exc_pkg;
  // ****************************************************
  // status word layout
  // ****************************************************
  localparam int DIVZERO_BIT = 2;
  localparam int OVERFLOW_BIT = 3;
  localparam int UNDERFLOW_BIT = 4;
  localparam int ERROR_SUMMARY_BIT = 7;
  localparam int ROUND_UP_BIT = 9;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  // ****************************************************
  // exponent figures
  // ****************************************************
  localparam int REBIAS = 24576;
  localparam int EXT_BIAS = 16383;
  localparam int SINGLE_MAX = 127;
  localparam int SINGLE_MIN = -126;
  localparam int DOUBLE_MAX = 1023;
  localparam int DOUBLE_MIN = -1022;
  localparam int EXT_MAX = 16383;
  localparam int EXT_MIN = -16382;
  localparam int SINGLE_PREC = 24;
  localparam int DOUBLE_PREC = 53;
  localparam logic [14:0] EXP_INF = 15'h7fff;
  localparam logic [14:0] EXP_ZERO = 15'h0000;
  localparam logic [1:0] RC_NEAREST = 2'h0;
  localparam logic [1:0] RC_DOWN = 2'h1;
  localparam logic [1:0] RC_UP = 2'h2;
  // ****************************************************
  // types
  // ****************************************************
  typedef enum logic [3:0] {
    OP_DIVIDE, OP_REV_DIVIDE, OP_REV_DIVIDE_POP, OP_INT_DIVIDE,
    OP_INT_REV_DIVIDE, OP_LOG2_MULTIPLY, OP_EXP_EXTRACT, OP_SCALE,
    OP_FLOAT_STORE, OP_FLOAT_STORE_POP, OP_INT_STORE, OP_OTHER_ARITH
  } op_type;
  typedef enum logic [2:0] {
    FMT_SINGLE, FMT_DOUBLE, FMT_EXTENDED, FMT_INTEGER, FMT_PACKED
  } fmt_type;
endpackage : fpu_exc_pkg

// [src/fpu_exc_unit.sv]
// exception detection and response for divide-by-zero, overflow, underflow
module fpu_exc_unit #(
  parameter int EXP_W = 18,
  parameter int SIG_W = 64
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // control word
  input wire logic divzero_mask_i,
  input wire logic overflow_mask_i,
  input wire logic underflow_mask_i,
  input wire logic [1:0] round_mode_i,
  input wire logic clear_flags_i,
  // operation from the datapath
  input wire logic op_valid_i,
  input wire fpu_exc_pkg::op_type op_code_i,
  input wire fpu_exc_pkg::fmt_type dest_format_i,
  input wire logic dest_is_reg_i,
  input wire logic a_sign_i,
  input wire logic a_zero_i,
  input wire logic a_finite_i,
  input wire logic b_sign_i,
  input wire logic b_zero_i,
  input wire logic res_sign_i,
  input wire logic signed [EXP_W-1:0] res_exp_i,
  input wire logic [SIG_W-1:0] res_sig_i,
  input wire logic res_rounded_up_i,
  input wire logic int_range_err_i,
  // instruction issue
  input wire logic check_pending_i,
  // results
  output logic result_valid_o,
  output logic dest_write_o,
  output logic dest_sign_o,
  output logic [14:0] dest_exp_o,
  output logic [SIG_W-1:0] dest_sig_o,
  output logic second_write_o,
  output logic stack_hold_o,
  output logic invalid_o,
  output logic [15:0] status_word_o,
  output logic handler_trap_o
);
  // ****************************************************
  // parameter checks
  // ****************************************************
  if (SIG_W != 64) $error("significand width must be 64");
  if (EXP_W < 17 || EXP_W > 30) $error("exponent width out of range");

  typedef logic signed [EXP_W-1:0] exp_type;

  function automatic exp_type fmt_max(fpu_exc_pkg::fmt_type f);
    if (f == fpu_exc_pkg::FMT_SINGLE) return exp_type'(fpu_exc_pkg::SINGLE_MAX);
    if (f == fpu_exc_pkg::FMT_DOUBLE) return exp_type'(fpu_exc_pkg::DOUBLE_MAX);
    return exp_type'(fpu_exc_pkg::EXT_MAX);
  endfunction : fmt_max

  function automatic exp_type fmt_min(fpu_exc_pkg::fmt_type f);
    if (f == fpu_exc_pkg::FMT_SINGLE) return exp_type'(fpu_exc_pkg::SINGLE_MIN);
    if (f == fpu_exc_pkg::FMT_DOUBLE) return exp_type'(fpu_exc_pkg::DOUBLE_MIN);
    return exp_type'(fpu_exc_pkg::EXT_MIN);
  endfunction : fmt_min

  function automatic logic [14:0] encode(exp_type e);
    exp_type b;
    b = e + exp_type'(fpu_exc_pkg::EXT_BIAS);
    return b[14:0];
  endfunction : encode

  // ****************************************************
  // decode
  // ****************************************************
  wire op_divide = op_code_i inside {fpu_exc_pkg::OP_DIVIDE,
    fpu_exc_pkg::OP_REV_DIVIDE, fpu_exc_pkg::OP_REV_DIVIDE_POP,
    fpu_exc_pkg::OP_INT_DIVIDE, fpu_exc_pkg::OP_INT_REV_DIVIDE};
  wire op_log2 = op_code_i == fpu_exc_pkg::OP_LOG2_MULTIPLY;
  wire op_extract = op_code_i == fpu_exc_pkg::OP_EXP_EXTRACT;
  wire op_scale = op_code_i == fpu_exc_pkg::OP_SCALE;
  wire op_int_store = op_code_i == fpu_exc_pkg::OP_INT_STORE;
  wire divides = op_divide | op_log2 | op_extract;
  // extract splits any zero; the others need a finite non-zero dividend
  wire dz_hit = op_valid_i & divides & b_zero_i
    & (op_extract | (a_finite_i & ~a_zero_i));
  // integer and packed stores never reach the range checks
  wire range_ok = op_valid_i & ~dz_hit & ~op_int_store;
  wire exp_type emax = fmt_max(dest_format_i);
  wire exp_type emin = fmt_min(dest_format_i);
  wire ov_hit = range_ok & (res_exp_i > emax);
  wire un_hit = range_ok & (res_sig_i != '0) & (res_exp_i < emin);
  wire dz_trap = dz_hit & ~divzero_mask_i;
  wire ov_trap = ov_hit & ~overflow_mask_i;
  wire un_trap = un_hit & ~underflow_mask_i;
  wire any_trap = dz_trap | ov_trap | un_trap;
  wire exp_type rebias = exp_type'(fpu_exc_pkg::REBIAS);
  wire exp_type reb_exp = ov_hit ? res_exp_i - rebias
    : res_exp_i + rebias;
  wire scale_inf = op_scale & ov_hit
    & (reb_exp > exp_type'(fpu_exc_pkg::EXT_MAX));
  wire scale_zero = op_scale & un_hit
    & (reb_exp < exp_type'(fpu_exc_pkg::EXT_MIN));
  // nearest, or directed rounding away from zero, gives infinity
  wire ov_to_inf = (round_mode_i == fpu_exc_pkg::RC_NEAREST)
    | ((round_mode_i == fpu_exc_pkg::RC_DOWN) & res_sign_i)
    | ((round_mode_i == fpu_exc_pkg::RC_UP) & ~res_sign_i);
  wire [SIG_W-1:0] big_sig = (dest_format_i == fpu_exc_pkg::FMT_SINGLE)
    ? {{fpu_exc_pkg::SINGLE_PREC{1'b1}}, {(SIG_W-fpu_exc_pkg::SINGLE_PREC){1'b0}}}
    : (dest_format_i == fpu_exc_pkg::FMT_DOUBLE)
    ? {{fpu_exc_pkg::DOUBLE_PREC{1'b1}}, {(SIG_W-fpu_exc_pkg::DOUBLE_PREC){1'b0}}}
    : '1;
  wire exp_type den_shift = emin - res_exp_i;
  // shifts of the full width or more flush to zero
  wire [SIG_W-1:0] den_sig = (den_shift >= exp_type'(SIG_W)) ? '0
    : res_sig_i >> den_shift;
  wire [14:0] den_exp = ((den_sig == '0)
    | (dest_format_i == fpu_exc_pkg::FMT_EXTENDED)) ? fpu_exc_pkg::EXP_ZERO
    : encode(emin);

  // ****************************************************
  // result selection
  // ****************************************************
  logic next_write;
  logic next_sign;
  logic [14:0] next_exp;
  logic [SIG_W-1:0] next_sig;
  logic next_second;
  logic next_hold;
  logic next_c1_load;
  logic next_c1;

  always_comb
  begin
    next_write = op_valid_i;
    next_sign = res_sign_i;
    next_exp = encode(res_exp_i);
    next_sig = res_sig_i;
    next_second = 1'b0;
    next_hold = 1'b0;
    next_c1_load = 1'b0;
    next_c1 = 1'b0;
    if (dz_trap | ((ov_trap | un_trap) & ~dest_is_reg_i))
    begin
      // faults that leave the destination and stack untouched for the handler
      next_write = 1'b0;
      next_hold = 1'b1;
      next_c1_load = ~dz_trap;
    end
    else if (dz_hit)
    begin
      next_exp = fpu_exc_pkg::EXP_INF;
      next_sig = {1'b1, {(SIG_W-1){1'b0}}};
      next_sign = a_sign_i ^ b_sign_i;
      if (op_log2)
        next_sign = ~a_sign_i;
      if (op_extract)
      begin
        next_second = 1'b1;
        next_sign = b_sign_i;
        next_exp = fpu_exc_pkg::EXP_ZERO;
        next_sig = '0;
      end
    end
    else if (ov_trap | un_trap)
    begin
      next_exp = encode(reb_exp);
      next_c1_load = 1'b1;
      next_c1 = res_rounded_up_i;
      if (scale_inf)
      begin
        next_exp = fpu_exc_pkg::EXP_INF;
        next_sig = {1'b1, {(SIG_W-1){1'b0}}};
      end
      if (scale_zero)
      begin
        next_exp = fpu_exc_pkg::EXP_ZERO;
        next_sig = '0;
      end
    end
    else if (ov_hit)
    begin
      next_exp = ov_to_inf ? fpu_exc_pkg::EXP_INF : encode(emax);
      next_sig = ov_to_inf ? {1'b1, {(SIG_W-1){1'b0}}} : big_sig;
    end
    else if (un_hit)
    begin
      next_exp = den_exp;
      next_sig = den_sig;
    end
  end

  // ****************************************************
  // status flags
  // ****************************************************
  logic divzero_flag;
  logic overflow_flag;
  logic underflow_flag;
  logic error_summary_flag;
  logic round_up_condition_bit;

  // a new event wins over a clear in the same cycle
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      divzero_flag <= 1'b0;
      overflow_flag <= 1'b0;
      underflow_flag <= 1'b0;
      error_summary_flag <= 1'b0;
      round_up_condition_bit <= 1'b0;
    end
    else
    begin
      divzero_flag <= dz_hit | (divzero_flag & ~clear_flags_i);
      overflow_flag <= ov_hit | (overflow_flag & ~clear_flags_i);
      underflow_flag <= un_hit | (underflow_flag & ~clear_flags_i);
      error_summary_flag <= any_trap
        | (error_summary_flag & ~clear_flags_i);
      if (next_c1_load)
        round_up_condition_bit <= next_c1;
    end
  end

  // ****************************************************
  // registered outputs
  // ****************************************************
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      result_valid_o <= 1'b0;
      dest_write_o <= 1'b0;
      dest_sign_o <= 1'b0;
      dest_exp_o <= fpu_exc_pkg::EXP_ZERO;
      dest_sig_o <= '0;
      second_write_o <= 1'b0;
      stack_hold_o <= 1'b0;
      invalid_o <= 1'b0;
      handler_trap_o <= 1'b0;
    end
    else
    begin
      result_valid_o <= op_valid_i;
      dest_write_o <= next_write;
      dest_sign_o <= next_sign;
      dest_exp_o <= next_exp;
      dest_sig_o <= next_sig;
      second_write_o <= next_second;
      stack_hold_o <= next_hold;
      invalid_o <= op_valid_i & op_int_store & int_range_err_i;
      // trap is taken only when the core polls the summary flag
      handler_trap_o <= check_pending_i & error_summary_flag;
    end
  end

  // status word is pure wiring of flops, reserved bits zero
  always_comb
  begin
    status_word_o = fpu_exc_pkg::STATUS_RESET;
    status_word_o[fpu_exc_pkg::DIVZERO_BIT] = divzero_flag;
    status_word_o[fpu_exc_pkg::OVERFLOW_BIT] = overflow_flag;
    status_word_o[fpu_exc_pkg::UNDERFLOW_BIT] = underflow_flag;
    status_word_o[fpu_exc_pkg::ERROR_SUMMARY_BIT] = error_summary_flag;
    status_word_o[fpu_exc_pkg::ROUND_UP_BIT] = round_up_condition_bit;
  end

  // ****************************************************
  // assertions
  // ****************************************************
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_unmasked_dz;
    dz_hit && !divzero_mask_i;
  endsequence
  sequence s_machine_kept;
    stack_hold_o && !dest_write_o && error_summary_flag;
  endsequence

  a_dz_flag_set: assert property (dz_hit |=> status_word_o[2])
    else $error("divide-by-zero flag not set");
  a_dz_masked_go: assert property (dz_hit && divzero_mask_i
    && !ov_trap && !un_trap |=> dest_write_o && !stack_hold_o)
    else $error("masked divide-by-zero did not write");
  a_dz_unmasked_hold: assert property (s_unmasked_dz |=> s_machine_kept)
    else $error("unmasked divide-by-zero changed state");
  a_div_inf_sign: assert property (dz_hit && divzero_mask_i && op_divide
    |=> dest_exp_o == 15'h7fff && dest_sign_o == $past(a_sign_i ^ b_sign_i))
    else $error("wrong signed infinity on divide");
  a_int_store_quiet: assert property (op_valid_i && op_int_store
    && !clear_flags_i |=> $stable(status_word_o[4:3]))
    else $error("integer store raised overflow or underflow");
  a_ovf_mem_hold: assert property (ov_trap && !dest_is_reg_i
    |=> !dest_write_o && !round_up_condition_bit)
    else $error("unmasked overflow wrote memory");
  a_round_up_bit: assert property ((ov_trap || un_trap) && dest_is_reg_i
    && !dz_hit |=> status_word_o[9] == $past(res_rounded_up_i))
    else $error("round-up bit wrong after rebias");
  a_trap_on_check: assert property (error_summary_flag && check_pending_i
    |=> handler_trap_o)
    else $error("pending fault not trapped");
  a_no_trap_idle: assert property (handler_trap_o
    |-> $past(check_pending_i && error_summary_flag))
    else $error("trap without pending fault");
endmodule : fpu_exc_unit

// [verification/core_model.sv]
// core-side model: issues waiting instructions and takes handler traps
module core_model
(
  // clock
  input wire logic sys_clk_i,
  // from the bench and the unit
  input wire logic poll_req_i,
  input wire logic handler_trap_o,
  // to the unit and the bench
  output logic check_pending_i,
  output logic trap_seen_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic busy = 1'b0;
  // a second poll is held back while a trap may still be in flight
  assign check_pending_i = poll_req_i & ~busy;
  initial trap_seen_o = 1'b0;
  always @(posedge sys_clk_i)
  begin
    busy <= check_pending_i;
    if (check_pending_i)
      trap_seen_o <= 1'b0;
    else if (handler_trap_o)
      trap_seen_o <= 1'b1;
  end
endmodule : core_model

// [verification/tb_top.sv]
// self-checking bench for the divide-by-zero, overflow, underflow unit
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {
    logic wr; logic wc; logic vc; logic sg; logic [14:0] ex;
    logic sec; logic hd; logic hc; logic inv; logic [15:0] st;
    logic [15:0] sm; logic [15:0] sh;
  } note_type;
  // ****************************************************
  // signals
  // ****************************************************
  logic sys_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic divzero_mask_i = 1'b0;
  logic overflow_mask_i = 1'b0;
  logic underflow_mask_i = 1'b0;
  logic [1:0] round_mode_i = 2'h0;
  logic clear_flags_i = 1'b0;
  logic op_valid_i = 1'b0;
  fpu_exc_pkg::op_type op_code_i = fpu_exc_pkg::OP_OTHER_ARITH;
  fpu_exc_pkg::fmt_type dest_format_i = fpu_exc_pkg::FMT_EXTENDED;
  logic dest_is_reg_i = 1'b1;
  logic a_sign_i = 1'b0;
  logic a_zero_i = 1'b0;
  logic a_finite_i = 1'b1;
  logic b_sign_i = 1'b0;
  logic b_zero_i = 1'b0;
  logic res_sign_i = 1'b0;
  logic signed [17:0] res_exp_i = 18'h00000;
  logic [63:0] res_sig_i = 64'h8000000000000000;
  logic res_rounded_up_i = 1'b0;
  logic int_range_err_i = 1'b0;
  logic check_pending_i, poll_req_i = 1'b0, trap_seen_o;
  logic result_valid_o, dest_write_o, dest_sign_o, second_write_o;
  logic stack_hold_o, invalid_o, handler_trap_o;
  logic [14:0] dest_exp_o;
  logic [63:0] dest_sig_o;
  logic [15:0] status_word_o;
  logic [15:0] st_m = 16'h0000;
  logic ru_k = 1'b0;
  logic fin = 1'b1;
  int failures = 0;
  int compares = 0;
  int cyc = 0;
  int k;
  note_type q[$];
  note_type n;
  always #50 sys_clk_i = ~sys_clk_i;
  fpu_exc_unit u_dut (.sys_clk_i, .sys_rst_i, .divzero_mask_i,
    .overflow_mask_i, .underflow_mask_i, .round_mode_i, .clear_flags_i,
    .op_valid_i, .op_code_i, .dest_format_i, .dest_is_reg_i, .a_sign_i,
    .a_zero_i, .a_finite_i, .b_sign_i, .b_zero_i, .res_sign_i, .res_exp_i,
    .res_sig_i, .res_rounded_up_i, .int_range_err_i, .check_pending_i,
    .result_valid_o, .dest_write_o, .dest_sign_o, .dest_exp_o, .dest_sig_o,
    .second_write_o, .stack_hold_o, .invalid_o, .status_word_o,
    .handler_trap_o);
  core_model u_core (.sys_clk_i, .poll_req_i, .handler_trap_o,
    .check_pending_i, .trap_seen_o);
  // ****************************************************
  // tasks
  // ****************************************************
  task automatic cmp(input string nm, input logic [15:0] e,
    input logic [15:0] s);
    compares++;
    if (s !== e)
    begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : cmp
  task automatic end_sim;
    if (q.size() != 0)
      failures++;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_sim
  task automatic op(input fpu_exc_pkg::op_type c,
    input fpu_exc_pkg::fmt_type f, input logic r, input logic za,
    input logic zb, input int e, input logic m);
    note_type w;
    logic sa, sb, sr, ru, dz, ov, un;
    logic [63:0] rs;
    int emax, emin, b;
    rs = {1'b1, 31'($urandom), 32'($urandom)};
    sa = 1'($urandom);
    sb = 1'($urandom);
    sr = 1'($urandom);
    ru = 1'($urandom);
    w = '{default: '0};
    emax = f == fpu_exc_pkg::FMT_SINGLE ? fpu_exc_pkg::SINGLE_MAX :
      f == fpu_exc_pkg::FMT_DOUBLE ? fpu_exc_pkg::DOUBLE_MAX :
      fpu_exc_pkg::EXT_MAX;
    emin = f == fpu_exc_pkg::FMT_SINGLE ? fpu_exc_pkg::SINGLE_MIN :
      f == fpu_exc_pkg::FMT_DOUBLE ? fpu_exc_pkg::DOUBLE_MIN :
      fpu_exc_pkg::EXT_MIN;
    dz = c <= fpu_exc_pkg::OP_EXP_EXTRACT && zb && !za && fin;
    ov = e > emax;
    un = e < emin;
    w.wr = 1'b1;
    w.wc = 1'b1;
    w.vc = 1'b1;
    w.hc = 1'b1;
    w.sg = sr;
    w.ex = 15'(e + fpu_exc_pkg::EXT_BIAS);
    if (dz)
    begin
      st_m[2] = 1'b1;
      w.sec = m && c == fpu_exc_pkg::OP_EXP_EXTRACT;
      w.sg = c == fpu_exc_pkg::OP_LOG2_MULTIPLY ? !sa : w.sec ? sb : sa ^ sb;
      w.ex = w.sec ? 15'h0000 : 15'h7fff;
      w.wr = m;
      w.hd = !m;
      st_m[7] = st_m[7] | !m;
    end
    else if (c == fpu_exc_pkg::OP_INT_STORE)
    begin
      w.inv = ov;
      w.wc = 1'b0;
      w.hc = 1'b0;
    end
    else if (ov || un)
    begin
      st_m[ov ? 3 : 4] = 1'b1;
      if (m && un)
        w.vc = 1'b0;
      else if (m)
        w.ex = (round_mode_i == 2'h0 || round_mode_i == 2'h2 && !sr ||
          round_mode_i == 2'h1 && sr) ? 15'h7fff :
          15'(emax + fpu_exc_pkg::EXT_BIAS);
      else if (r)
      begin
        b = e + fpu_exc_pkg::EXT_BIAS +
          (ov ? -fpu_exc_pkg::REBIAS : fpu_exc_pkg::REBIAS);
        w.ex = b >= 32767 ? 15'h7fff : b <= 0 ? 15'h0000 : 15'(b);
        w.hc = 1'b0;
        st_m[9] = ru;
      end
      else
      begin
        w.wr = 1'b0;
        w.hd = 1'b1;
        st_m[9] = 1'b0;
      end
      st_m[7] = st_m[7] | !m;
      ru_k = ru_k | !m;
    end
    w.st = st_m;
    w.sm = ru_k ? 16'hffff : 16'hfdff;
    w.sh = w.ex == 15'h7fff ? 16'h8000 : w.ex == 15'h0000 ? 16'h0000 :
      rs[63:48];
    if (m && ov && !dz && w.ex != 15'h7fff)
      w.sh = 16'hffff;
    q.push_back(w);
    {divzero_mask_i, overflow_mask_i, underflow_mask_i} = {3{m}};
    op_code_i = c;
    dest_format_i = f;
    dest_is_reg_i = r;
    {a_sign_i, a_zero_i, a_finite_i, b_sign_i, b_zero_i} =
      {sa, za, fin, sb, zb};
    {res_sign_i, res_rounded_up_i, int_range_err_i} = {sr, ru, ov};
    res_exp_i = 18'(e);
    res_sig_i = rs;
    op_valid_i = 1'b1;
    @(negedge sys_clk_i);
  endtask : op
  task automatic poll(input logic t);
    op_valid_i = 1'b0;
    poll_req_i = 1'b1;
    @(negedge sys_clk_i);
    poll_req_i = 1'b0;
    @(negedge sys_clk_i);
    cmp("trap", 16'(t), 16'(trap_seen_o));
  endtask : poll
  task automatic clear;
    op_valid_i = 1'b0;
    clear_flags_i = 1'b1;
    @(negedge sys_clk_i);
    clear_flags_i = 1'b0;
    st_m = st_m & 16'hfd63;
    ru_k = 1'b0;
    cmp("status", st_m & 16'hfdff, status_word_o & 16'hfdff);
  endtask : clear
  // ****************************************************
  // result monitor and watchdog
  // ****************************************************
  always @(negedge sys_clk_i)
    if (result_valid_o === 1'b1)
    begin
      if (q.size() == 0)
        cmp("spurious result", 16'h0000, 16'h0001);
      else
      begin
        n = q.pop_front();
        if (n.wc)
          cmp("dest write", 16'(n.wr), 16'(dest_write_o));
        if (n.wc && n.wr && n.vc)
        begin
          cmp("dest value", {n.sg, n.ex}, {dest_sign_o, dest_exp_o});
          cmp("dest significand", n.sh, dest_sig_o[63:48]);
        end
        cmp("second write", 16'(n.sec), 16'(second_write_o));
        cmp("invalid", 16'(n.inv), 16'(invalid_o));
        if (n.hc)
          cmp("stack hold", 16'(n.hd), 16'(stack_hold_o));
        cmp("status", n.st & n.sm, status_word_o & n.sm);
      end
    end
  always @(posedge sys_clk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      failures++;
      end_sim;
    end
  end
  // ****************************************************
  // tests
  // ****************************************************
  initial
  begin
    void'($urandom(54890));
    repeat (8) @(negedge sys_clk_i);
    sys_rst_i = 1'b0;
    cmp("reset status", fpu_exc_pkg::STATUS_RESET, status_word_o);
    for (k = 0; k < 10; k++)
      op(fpu_exc_pkg::op_type'(k / 2), fpu_exc_pkg::FMT_EXTENDED, 1'b1, 0, 1,
        5, 1'(k));
    op(fpu_exc_pkg::OP_LOG2_MULTIPLY, fpu_exc_pkg::FMT_EXTENDED, 1, 0, 1, 3,
      1);
    op(fpu_exc_pkg::OP_EXP_EXTRACT, fpu_exc_pkg::FMT_EXTENDED, 1, 0, 1, 3,
      1);
    poll(1'b1);
    clear;
    op(fpu_exc_pkg::OP_SCALE, fpu_exc_pkg::FMT_EXTENDED, 1, 0, 1, 2, 0);
    op(fpu_exc_pkg::OP_OTHER_ARITH, fpu_exc_pkg::FMT_EXTENDED, 1, 0, 1, 2,
      0);
    op(fpu_exc_pkg::OP_DIVIDE, fpu_exc_pkg::FMT_EXTENDED, 1, 1, 1, 2, 0);
    fin = 1'b0;
    op(fpu_exc_pkg::OP_DIVIDE, fpu_exc_pkg::FMT_EXTENDED, 1, 0, 1, 2, 0);
    fin = 1'b1;
    poll(1'b0);
    $display("test divide by zero done");
    for (k = 0; k < 8; k++)
    begin
      round_mode_i = 2'(k);
      op(fpu_exc_pkg::OP_FLOAT_STORE, fpu_exc_pkg::FMT_SINGLE, 0, 0, 0,
        128 + $urandom % 900, 1);
    end
    op(fpu_exc_pkg::OP_FLOAT_STORE_POP, fpu_exc_pkg::FMT_DOUBLE, 0, 0, 0,
      1024, 0);
    op(fpu_exc_pkg::OP_OTHER_ARITH, fpu_exc_pkg::FMT_EXTENDED, 1, 0, 0,
      16384 + $urandom % 8000, 0);
    op(fpu_exc_pkg::OP_SCALE, fpu_exc_pkg::FMT_EXTENDED, 1, 0, 0,
      40960 + $urandom % 500, 0);
    poll(1'b1);
    clear;
    $display("test overflow done");
    op(fpu_exc_pkg::OP_FLOAT_STORE, fpu_exc_pkg::FMT_SINGLE, 0, 0, 0,
      -127 - $urandom % 800, 1);
    poll(1'b0);
    op(fpu_exc_pkg::OP_FLOAT_STORE, fpu_exc_pkg::FMT_DOUBLE, 0, 0, 0,
      -1023, 0);
    op(fpu_exc_pkg::OP_OTHER_ARITH, fpu_exc_pkg::FMT_EXTENDED, 1, 0, 0,
      -16383 - $urandom % 8000, 0);
    op(fpu_exc_pkg::OP_SCALE, fpu_exc_pkg::FMT_EXTENDED, 1, 0, 0,
      -40959 - $urandom % 500, 0);
    poll(1'b1);
    clear;
    $display("test underflow done");
    op(fpu_exc_pkg::OP_INT_STORE, fpu_exc_pkg::FMT_INTEGER, 0, 0, 0, 20000,
      0);
    op(fpu_exc_pkg::OP_INT_STORE, fpu_exc_pkg::FMT_PACKED, 0, 0, 0, -17000,
      0);
    poll(1'b0);
    $display("test integer store done");
    end_sim;
  end
endmodule : tb_top
